// >>> common/poss_pkg.sv
// Purpose: Constants for the power-on strap sampler
// Assumes: 32-bit memory address/data bus, straps low by default
// Notes: Functional notes below list the behaviour in short form
//
// Functional notes
// - Bus undriven in reset, capture on release
// - Unpulled strap reads low, low default
// - Bit 31 high means static memory attached
// - Bit 30 picks ordinary or nonvolatile RAM
// - Bit 16 low enables extended bus mode
// - Bit 15 low enables 133 MHz operation
// - Bit 14 low gives 64-bit bus width
// - Bit 13 low enables 66 MHz operation
// - Bit 10 low enables MSI-X interrupts
// - Bit 8 high marks hot swap present
// - Bit 7 low lets processor boot run
// - Bit 5 loads subsystem id bit 15
// - Bit 3 loads device id bit 0
// - Bits 2:1 give flash size code
// - Reserved strap bits have no effect
package poss_pkg;

    // ------------------------------------------------------------
    // Bus geometry and strap positions
    // ------------------------------------------------------------
    localparam int BUS_W = 32;
    localparam int SRAM_PRESENT_BIT = 31;
    localparam int SRAM_TYPE_BIT = 30;
    localparam int PCIX_DIS_BIT = 16;
    localparam int PCIX133_DIS_BIT = 15;
    localparam int BUS32_BIT = 14;
    localparam int PCI66_DIS_BIT = 13;
    localparam int MSIX_DIS_BIT = 10;
    localparam int HOTSWAP_BIT = 8;
    localparam int BOOT_DIS_BIT = 7;
    localparam int SUBSYS_ID_BIT = 5;
    localparam int DEV_ID_BIT = 3;
    localparam int FLASH_HI_BIT = 2;
    localparam int FLASH_LO_BIT = 1;

    // Bits that carry a setting; the rest are reserved
    localparam logic [31:0] USED_MASK = 32'hc001e5ae;

    // Reset value of every captured strap
    localparam logic [31:0] STRAP_RESET = 32'h00000000;
    localparam logic [1:0] FLASH_RESET = 2'h0;

    // Flash size codes as seen on the straps
    localparam logic [1:0] FLASH_CODE_2MB = 2'h1;
    localparam logic [1:0] FLASH_CODE_4MB = 2'h2;

    // Output enable level while the bus is released
    localparam logic [31:0] OE_RELEASED = 32'hffffffff;

    // Sampler phases
    typedef enum logic [1:0] {
        POSS_SAMPLE,
        POSS_HOLD
    } poss_state_t;

endpackage : poss_pkg

// >>> rtl/poss_capture.sv
// Purpose: Continuous strap sampling register with latch on release
// Assumes: Bus inputs synchronous to ref_clk_in
// Notes: Holds the last sample taken while host reset was low
`timescale 1ns/1ps
module poss_capture
    import poss_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic sample_in,
    input wire logic [31:0] bus_in,
    output logic [31:0] strap_out
);

    // ------------------------------------------------------------
    // Sample register
    // ------------------------------------------------------------
    // Reserved bits are forced low so they carry nothing onward
    wire [31:0] masked_bus = bus_in & USED_MASK;

    // Track the bus every cycle while sampling, freeze otherwise
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            strap_out <= STRAP_RESET;
        end else if (sample_in) begin
            strap_out <= masked_bus;
        end
    end

endmodule : poss_capture

// >>> rtl/poss_sampler.sv
// Purpose: Power-on strap sampler turning memory bus straps to settings
// Assumes: Host bus reset input synchronous to ref_clk_in
// Notes: Settings change only at host reset release and at chip reset
`timescale 1ns/1ps
module poss_sampler
    import poss_pkg::*;
(
    input wire logic ref_clk_in, // 200 MHz system clock
    input wire logic arst_n_in, // Chip reset, async low
    input wire logic host_rst_n_in, // Host bus reset, low active
    input wire logic [31:0] mem_addr_data_bus_in, // Strap pins
    output logic [31:0] mem_addr_data_bus_oe_n_out, // Low drives pin
    output logic straps_valid_out, // Settings captured
    output logic sram_present_out, // Static RAM attached
    output logic nonvolatile_static_ram_out, // Type is nonvolatile
    output logic pcix_enable_out, // Extended bus mode allowed
    output logic pcix_133_enable_out, // 133 MHz allowed
    output logic bus_64bit_out, // 64-bit host bus
    output logic pci_66_enable_out, // 66 MHz allowed
    output logic msix_enable_out, // MSI-X allowed
    output logic hot_swap_enable_out, // Hot swap on board
    output logic embedded_io_processor_boot_out, // Boot may run
    output logic subsys_id_bit15_out, // Subsystem id bit 15
    output logic device_id_bit0_out, // Device id bit 0
    output logic [1:0] flash_size_code_out // Raw flash size code
);

    // ------------------------------------------------------------
    // Phase control
    // ------------------------------------------------------------
    poss_state_t state; // Current phase
    poss_state_t next_state; // Next phase
    logic [31:0] strap; // Captured straps

    // Sample whenever the host reset is low; hold once it lifts
    wire in_host_reset = !host_rst_n_in;
    wire sampling = in_host_reset;
    wire releasing = (state == POSS_SAMPLE) && !in_host_reset;

    // Phase transitions
    always_comb begin
        next_state = state;
        unique case (state)
            POSS_SAMPLE: begin
                // Release ends the sampling window
                if (!in_host_reset) begin
                    next_state = POSS_HOLD;
                end
            end
            POSS_HOLD: begin
                // Only a new host reset reopens sampling
                if (in_host_reset) begin
                    next_state = POSS_SAMPLE;
                end
            end
        endcase
    end

    // Phase register
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state <= POSS_SAMPLE;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------
    poss_capture u_capture (
        .ref_clk_in(ref_clk_in),
        .arst_n_in(arst_n_in),
        .sample_in(sampling),
        .bus_in(mem_addr_data_bus_in),
        .strap_out(strap)
    );

    // ------------------------------------------------------------
    // Decode of the captured straps
    // ------------------------------------------------------------
    // Decoding reads the held copy, so settings stay put after release
    wire d_present = strap[SRAM_PRESENT_BIT];
    // Type only has meaning when a memory is present
    wire d_nv = strap[SRAM_PRESENT_BIT] & strap[SRAM_TYPE_BIT];
    wire d_pcix = !strap[PCIX_DIS_BIT];
    wire d_pcix133 = !strap[PCIX133_DIS_BIT];
    wire d_bus64 = !strap[BUS32_BIT];
    wire d_pci66 = !strap[PCI66_DIS_BIT];
    wire d_msix = !strap[MSIX_DIS_BIT];
    wire d_hotswap = strap[HOTSWAP_BIT];
    wire d_boot = !strap[BOOT_DIS_BIT];
    wire d_subsys = strap[SUBSYS_ID_BIT];
    wire d_devid = strap[DEV_ID_BIT];
    // Code passes raw; size mapping is left to the flash controller
    wire [1:0] d_flash = {strap[FLASH_HI_BIT], strap[FLASH_LO_BIT]};

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    // Bus stays released for the whole host reset window
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mem_addr_data_bus_oe_n_out <= OE_RELEASED;
        end else if (in_host_reset) begin
            mem_addr_data_bus_oe_n_out <= OE_RELEASED;
        end
    end

    // Valid flag rises after release and drops on host reset
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            straps_valid_out <= 1'b0;
        end else if (in_host_reset) begin
            straps_valid_out <= 1'b0;
        end else if (state == POSS_HOLD) begin
            straps_valid_out <= 1'b1;
        end
    end

    // Settings load once, on the cycle after the release edge
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sram_present_out <= 1'b0;
            nonvolatile_static_ram_out <= 1'b0;
            pcix_enable_out <= 1'b1;
            pcix_133_enable_out <= 1'b1;
            bus_64bit_out <= 1'b1;
            pci_66_enable_out <= 1'b1;
            msix_enable_out <= 1'b1;
            hot_swap_enable_out <= 1'b0;
            embedded_io_processor_boot_out <= 1'b1;
            subsys_id_bit15_out <= 1'b0;
            device_id_bit0_out <= 1'b0;
            flash_size_code_out <= FLASH_RESET;
        end else if (releasing) begin
            sram_present_out <= d_present;
            nonvolatile_static_ram_out <= d_nv;
            pcix_enable_out <= d_pcix;
            pcix_133_enable_out <= d_pcix133;
            bus_64bit_out <= d_bus64;
            pci_66_enable_out <= d_pci66;
            msix_enable_out <= d_msix;
            hot_swap_enable_out <= d_hotswap;
            embedded_io_processor_boot_out <= d_boot;
            subsys_id_bit15_out <= d_subsys;
            device_id_bit0_out <= d_devid;
            flash_size_code_out <= d_flash;
        end
    end

endmodule : poss_sampler

// >>> tb/poss_board_pullups.sv
// Purpose: Board strap resistors on the memory bus
// Assumes: Device leaves the bus released
// Notes: Pins with no pull-up read the internal pull-down
`timescale 1ns/1ps
module poss_board_pullups (
    input wire logic [31:0] pullup_in, // Fitted pull-ups
    input wire logic [31:0] oe_n_in, // Device enables, low drives
    output logic [31:0] bus_out // Level at the pins
);
    // Released pin: pull-up wins, else pull-down gives low
    assign bus_out = pullup_in & oe_n_in;
endmodule : poss_board_pullups

// >>> tb/poss_sampler_checker.sv
// Purpose: Port checks of the strap sampler
// Assumes: Host reset rises only after two low edges
// Notes: Settings compared with the bus two edges back
`timescale 1ns/1ps
module poss_checker (
    input wire logic ref_clk_in, arst_n_in, host_rst_n_in,
    input wire logic [31:0] mem_addr_data_bus_in,
    input wire logic [31:0] mem_addr_data_bus_oe_n_out,
    input wire logic straps_valid_out, sram_present_out,
    input wire logic nonvolatile_static_ram_out, pcix_enable_out,
    input wire logic pcix_133_enable_out, bus_64bit_out,
    input wire logic pci_66_enable_out, msix_enable_out,
    input wire logic hot_swap_enable_out, subsys_id_bit15_out,
    input wire logic embedded_io_processor_boot_out, device_id_bit0_out,
    input wire logic [1:0] flash_size_code_out
);
    wire logic h = host_rst_n_in; // Short alias
    wire logic [31:0] b = mem_addr_data_bus_in; // Short alias
    // All settings together, for the hold check
    wire logic [12:0] s = {sram_present_out, nonvolatile_static_ram_out,
        pcix_enable_out, pcix_133_enable_out, bus_64bit_out,
        pci_66_enable_out, msix_enable_out, hot_swap_enable_out,
        embedded_io_processor_boot_out, subsys_id_bit15_out,
        device_id_bit0_out, flash_size_code_out};
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!arst_n_in);
    a_bus_released: assert property (&mem_addr_data_bus_oe_n_out)
        else $error("bus driven");
    a_sram_present: assert property ($rose(h) |=>
        sram_present_out == $past(b[31], 2)) else $error("present");
    a_mem_type: assert property ($rose(h) |=>
        nonvolatile_static_ram_out == $past(b[31] & b[30], 2))
        else $error("mem type");
    a_pcix_mode: assert property ($rose(h) |=>
        pcix_enable_out == !$past(b[16], 2)) else $error("pcix");
    a_host_speed: assert property ($rose(h) |=>
        {pcix_133_enable_out, bus_64bit_out, pci_66_enable_out}
        == ~$past(b[15:13], 2)) else $error("speed");
    a_msix_boot: assert property ($rose(h) |=>
        {msix_enable_out, embedded_io_processor_boot_out}
        == ~$past({b[10], b[7]}, 2)) else $error("msix boot");
    a_id_bits: assert property ($rose(h) |=>
        {hot_swap_enable_out, subsys_id_bit15_out, device_id_bit0_out,
        flash_size_code_out} == $past({b[8], b[5], b[3], b[2:1]}, 2))
        else $error("id bits");
    a_settings_hold: assert property (!$rose(h) |=> $stable(s))
        else $error("settings moved");
    a_valid_rise: assert property ($rose(h) |=>
        !straps_valid_out ##1 straps_valid_out) else $error("valid");
    a_valid_drop: assert property (!h |=> !straps_valid_out)
        else $error("valid held");
endmodule : poss_checker
bind poss_sampler poss_checker u_chk (.*);

// >>> tb/tb_power_on_strap_sampler.sv
// Purpose: Self-checking bench for the strap sampler
// Assumes: Straps come only from board pull-ups
// Notes: Reset check first, then row table, then timing and reset corners
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin bad_count++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, a, e); end end
module tb_power_on_strap_sampler;
    logic ref_clk_in = 0, arst_n_in = 0, host_rst_n_in = 0;
    logic [31:0] pull = 0, bus, oe_n; // Pull-ups, pins, enables
    logic valid, pres, nv, px, p133, b64, p66, msix, hot, boot, sub, dev;
    logic [1:0] fl;
    wire logic [12:0] out_v = {pres, nv, px, p133, b64, p66, msix, hot,
        boot, sub, dev, fl};
    int bad_count = 0, n_compared = 0;
    // Strap pattern beside expected settings
    logic [44:0] rows [18] = '{{32'h0, 13'h07d0}, {32'hffffffff, 13'h182f},
        {32'h3ffe1a51, 13'h07d0}, {32'h80000000, 13'h17d0},
        {32'h40000000, 13'h07d0}, {32'hc0000000, 13'h1fd0},
        {32'h10000, 13'h03d0}, {32'h8000, 13'h05d0}, {32'h4000, 13'h06d0},
        {32'h2000, 13'h0750}, {32'h400, 13'h0790}, {32'h100, 13'h07f0},
        {32'h80, 13'h07c0}, {32'h20, 13'h07d8}, {32'h8, 13'h07d4},
        {32'h2, 13'h07d1}, {32'h4, 13'h07d2}, {32'h6, 13'h07d3}};
    poss_board_pullups board (.pullup_in(pull), .oe_n_in(oe_n),
        .bus_out(bus));
    poss_sampler uut (.ref_clk_in, .arst_n_in, .host_rst_n_in,
        .mem_addr_data_bus_in(bus), .mem_addr_data_bus_oe_n_out(oe_n),
        .straps_valid_out(valid), .sram_present_out(pres),
        .nonvolatile_static_ram_out(nv), .pcix_enable_out(px),
        .pcix_133_enable_out(p133), .bus_64bit_out(b64),
        .pci_66_enable_out(p66), .msix_enable_out(msix),
        .hot_swap_enable_out(hot), .embedded_io_processor_boot_out(boot),
        .subsys_id_bit15_out(sub), .device_id_bit0_out(dev),
        .flash_size_code_out(fl));
    initial forever #2.5 ref_clk_in = ~ref_clk_in;
    task automatic tally_and_finish;
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : tally_and_finish
    // Host reset low for lo edges with straps st, then await valid
    task automatic capture(input logic [31:0] st, input int lo);
        int i;
        @(posedge ref_clk_in);
        host_rst_n_in <= 1'b0;
        pull <= st;
        repeat (lo) @(posedge ref_clk_in);
        host_rst_n_in <= 1'b1;
        for (i = 0; i < 6; i++) begin
            @(posedge ref_clk_in);
            #1;
            if (valid === 1'b1) break;
        end
        if (valid !== 1'b1) begin
            bad_count++;
            tally_and_finish();
        end
    endtask : capture
    initial begin
        repeat (2) @(posedge ref_clk_in);
        #1;
        `CHK({valid, out_v}, 14'h07d0)
        `CHK(oe_n, 32'hffffffff)
        @(posedge ref_clk_in) arst_n_in <= 1'b1;
        foreach (rows[k]) begin
            capture(rows[k][44:13], 3);
            `CHK(out_v, rows[k][12:0])
            pull <= ~rows[k][44:13]; // Ignored while host reset high
            repeat (2) @(posedge ref_clk_in);
            #1;
            `CHK(out_v, rows[k][12:0])
        end
        // Long low phase: only the final sample may count
        @(posedge ref_clk_in) host_rst_n_in <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
        capture(32'h80000000, 1);
        `CHK(out_v, 13'h17d0)
        // Chip reset mid-run restores the all-low decode
        @(posedge ref_clk_in);
        host_rst_n_in <= 1'b0;
        arst_n_in <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
        #1;
        `CHK({valid, out_v}, 14'h07d0)
        @(posedge ref_clk_in) arst_n_in <= 1'b1;
        capture(32'h20, 2);
        `CHK(out_v, 13'h07d8)
        tally_and_finish();
    end
endmodule : tb_power_on_strap_sampler
